// ### bench/fsc_flash_model.sv
// flash array model facing the protection block
module fsc_flash_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fsc_pkg::fsc_freq_s flash_req,
  output logic flash_busy,
  output logic flash_done,
  output logic [7:0] flash_rdata,
  output logic [7:0] flash_old,
  output logic [7:0] read_lock,
  output logic [7:0] write_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsc_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] scr [0:127];
  fsc_freq_s cur;
  int cnt;
  // blank array, read data junk until answered
  initial begin
    flash_rdata = 8'h5a;
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (scr[i]) scr[i] = 8'hff;
  end
  assign read_lock = mem[FSC_RLOCK_ADDR];
  assign write_lock = mem[FSC_WLOCK_ADDR];
  assign flash_old = flash_req.scratch ? scr[flash_req.addr[6:0]] : mem[flash_req.addr];
  assign flash_busy = cnt != 0;
  // reads answer fast, programs slowly
  // program only clears bits
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req.valid) begin
        cur <= flash_req;
        cnt <= flash_req.op == FSC_OP_READ ? 1 : 5;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        flash_done <= 1'b1;
        if (cur.op == FSC_OP_READ) flash_rdata <= cur.scratch ? scr[cur.addr[6:0]] : mem[cur.addr];
        else if (cur.span == FSC_ER_MASS) for (int i = 0; i < 'hfe00; i++) mem[i] <= 8'hff;
        else if (cur.span == FSC_ER_PAGE && cur.scratch) foreach (scr[i]) scr[i] <= 8'hff;
        else if (cur.span == FSC_ER_PAGE) for (int i = 0; i < 512; i++) mem[{cur.addr[15:9], 9'h0} + i] <= 8'hff;
        else if (cur.scratch) scr[cur.addr[6:0]] <= scr[cur.addr[6:0]] & cur.data;
        else mem[cur.addr] <= mem[cur.addr] & cur.data;
      end
    end
  end
endmodule

// ### bench/fsc_top_tb.sv
// self-checking bench for the flash protection block
module fsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fsc_pkg::*;
  logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, jscr = 0, stalled, denied;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, cpu_rdata, jtag_rdata, f_rd, f_old, rl, wl, v;
  logic [15:0] cpu_pc = 0;
  logic cpu_rvalid, cpu_stall, jtag_done, jtag_denied, f_busy, f_done, one_shot_en, read_always_en;
  fsc_req_s cpu_req = '0, jtag_req = '0;
  fsc_freq_s flash_req;
  int num_errors = 0, samples_checked = 0, cyc = 0;

  fsc_top uut (.clk(clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_req(cpu_req), .cpu_pc(cpu_pc), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .cpu_stall(cpu_stall), .jtag_req(jtag_req), .jtag_rdata(jtag_rdata),
    .jtag_done(jtag_done), .jtag_denied(jtag_denied), .flash_req(flash_req), .flash_busy(f_busy),
    .flash_done(f_done), .flash_rdata(f_rd), .flash_old(f_old), .read_lock_in(rl), .write_lock_in(wl),
    .one_shot_en(one_shot_en), .read_always_en(read_always_en));
  fsc_flash_model u_flash (.clk(clk), .sys_rst(sys_rst), .flash_req(flash_req), .flash_busy(f_busy),
    .flash_done(f_done), .flash_rdata(f_rd), .flash_old(f_old), .read_lock(rl), .write_lock(wl));

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  task automatic close_out;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // cut a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out;
    end
  end

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  function automatic logic [7:0] m(input logic [15:0] a);
    return u_flash.mem[a];
  endfunction

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 0;
  endtask

  task automatic sr(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_rd = 1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 0;
    d = sfr_rdata;
  endtask

  // request held until answered; denied software writes simply time out
  task automatic acc(input bit jt, input fsc_op_e op, input logic [15:0] a, input logic [7:0] d);
    bit fin;
    fin = 0;
    stalled = 0;
    denied = 0;
    @(negedge clk);
    if (jt) jtag_req = '{1'b1, jscr, op, a, d};
    else cpu_req = '{1'b1, 1'b0, op, a, d};
    for (int n = 0; n < 40 && !fin; n++) begin
      @(posedge clk);
      #1;
      if (cpu_stall === 1'b1) stalled = 1;
      if (jtag_denied === 1'b1) denied = 1;
      v = jt ? jtag_rdata : cpu_rdata;
      fin = jt ? jtag_done === 1'b1 : op == FSC_OP_READ ? cpu_rvalid === 1'b1 : stalled && cpu_stall === 1'b0;
    end
    @(negedge clk);
    jtag_req = '0;
    cpu_req = '0;
  endtask

  task automatic t_regs;
    sr(FSC_PSC_ADDR, v);
    chk("psc", v, 8'h00); // store control clear
    sr(FSC_FMC_ADDR, v);
    chk("fmc", v, 8'h80); // timer on
    chk("oneshot", {7'h0, one_shot_en}, 8'h01); // timer output
    sw(FSC_FMC_ADDR, 8'hff);
    sr(FSC_FMC_ADDR, v);
    chk("fmc_rsv", v, 8'hc1); // reserved zero
    chk("rdalw", {7'h0, read_always_en}, 8'h01); // read mode
    sw(FSC_FMC_ADDR, 8'h00);
  endtask

  task automatic t_write;
    sw(FSC_PSC_ADDR, 8'h01);
    acc(0, FSC_OP_WRITE, 16'h1234, 8'h0f);
    chk("nowe", m(16'h1234), 8'hff); // write gated
    sw(FSC_FMC_ADDR, 8'h01);
    acc(0, FSC_OP_WRITE, 16'h1234, 8'h0f);
    chk("prog", m(16'h1234), 8'h0f); // byte program
    chk("stall", {7'h0, stalled}, 8'h01); // core held
    acc(0, FSC_OP_WRITE, 16'h1234, 8'hf0);
    chk("clr", m(16'h1234), 8'h00); // bits only clear
    sw(FSC_PSC_ADDR, 8'h03);
    acc(0, FSC_OP_WRITE, 16'h1300, 8'h00);
    chk("pg_lo", m(16'h1200), 8'hff); // page start
    chk("pg_hi", m(16'h13ff), 8'hff); // page end
    chk("pg_nx", m(16'h1400), 8'h11); // next page kept
    acc(0, FSC_OP_WRITE, 16'hfc10, 8'h00);
    chk("lk_er", m(16'hfc10), 8'h22); // no erase
    sw(FSC_PSC_ADDR, 8'h01);
    acc(0, FSC_OP_WRITE, 16'hfc10, 8'h02);
    chk("lk_wr", m(16'hfc10), 8'h02); // write allowed
    sw(FSC_PSC_ADDR, 8'h05);
    acc(0, FSC_OP_WRITE, 16'h0010, 8'h3c);
    chk("sp_wr", u_flash.scr[16], 8'h3c); // scratch write
    chk("sp_main", m(16'h0010), 8'hff); // main kept
  endtask

  task automatic t_limit;
    sw(FSC_PSC_ADDR, 8'h01);
    cpu_pc = 16'h5000;
    acc(0, FSC_OP_READ, 16'h1000, 0);
    chk("lim0", v, 8'h77); // open limit
    sw(FSC_FAL_ADDR, 8'h40);
    sw(FSC_FAL_ADDR, 8'h80);
    sr(FSC_FAL_ADDR, v);
    chk("once", v, 8'h40); // first write only
    acc(0, FSC_OP_READ, 16'h3fff, 0);
    chk("below", v, 8'h00); // read hidden
    acc(0, FSC_OP_READ, 16'h4000, 0);
    chk("at", v, 8'h88); // limit boundary
    acc(0, FSC_OP_WRITE, 16'h1000, 8'h00);
    chk("upwr", m(16'h1000), 8'h77); // write blocked
    cpu_pc = 16'h3f00;
    acc(0, FSC_OP_READ, 16'h1000, 0);
    chk("lower", v, 8'h77); // lower code free
  endtask

  task automatic t_jtag;
    acc(1, FSC_OP_ERASE, 16'hfc20, 0);
    chk("tp_er", m(16'hfc10), 8'hff); // top page erased
    chk("tp_nx", m(16'hfa00), 8'h33); // other page kept
    acc(1, FSC_OP_WRITE, 16'hfdfe, 8'hfd);
    acc(1, FSC_OP_WRITE, 16'hfdff, 8'hfe);
    chk("rlock", m(16'hfdff), 8'hfe); // lock clearable
    acc(1, FSC_OP_READ, 16'h0100, 0);
    chk("rd_den", {7'h0, denied}, 8'h01); // read refused
    chk("rd_dat", v, 8'h00); // refused read returns zero
    acc(1, FSC_OP_READ, 16'h2100, 0);
    chk("rd_ok", v, 8'h99); // block one readable
    acc(1, FSC_OP_WRITE, 16'h2100, 8'h00);
    chk("wr_den", m(16'h2100), 8'h99); // write refused
    acc(1, FSC_OP_ERASE, 16'h3000, 0);
    chk("er_den", m(16'h3000), 8'h55); // erase refused
    acc(1, FSC_OP_ERASE, 16'hfdff, 0);
    chk("mass", m(16'h2100), 8'hff); // all erased
    chk("m_lock", m(16'hfdfe), 8'hff); // locks removed
    chk("m_resv", m(16'hfe00), 8'h44); // reserved kept
    acc(1, FSC_OP_WRITE, 16'hfdfe, 8'h7f);
    chk("top_wr", m(16'hfdfe), 8'h7f); // lock write allowed
    acc(1, FSC_OP_ERASE, 16'hfc20, 0);
    chk("top_er", m(16'hfdfe), 8'h7f); // lock erase refused
    jscr = 1;
    acc(1, FSC_OP_WRITE, 16'h0005, 8'h00);
    chk("sp_open", u_flash.scr[5], 8'h00); // scratch open while a block is open
    jscr = 0;
    acc(1, FSC_OP_WRITE, 16'hfdfe, 8'h00);
    chk("top_lk", m(16'hfdfe), 8'h00); // lock write with top locked
    jscr = 1;
    acc(1, FSC_OP_ERASE, 16'h0005, 0);
    chk("sp_den", {7'h0, denied}, 8'h01); // scratch locked with all
    chk("sp_keep", u_flash.scr[5], 8'h00); // scratch kept
    jscr = 0;
  endtask

  // mid-run reset rearms the one-shot limit
  task automatic t_reset;
    @(negedge clk);
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    sw(FSC_FAL_ADDR, 8'h20);
    sr(FSC_FAL_ADDR, v);
    chk("rearm", v, 8'h20); // first write after reset
    sr(FSC_FMC_ADDR, v);
    chk("fmc_rst", v, 8'h80); // reset value again
  endtask

  // reset, preload the array, run every scenario
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 0;
    u_flash.mem[16'h1000] = 8'h77;
    u_flash.mem[16'h1200] = 8'h00;
    u_flash.mem[16'h1400] = 8'h11;
    u_flash.mem[16'hfc10] = 8'h22;
    u_flash.mem[16'h4000] = 8'h88;
    u_flash.mem[16'h2100] = 8'h99;
    u_flash.mem[16'h3000] = 8'h55;
    u_flash.mem[16'hfa00] = 8'h33;
    u_flash.mem[16'hfe00] = 8'h44;
    t_regs;
    t_write;
    t_limit;
    t_reset;
    t_jtag;
    close_out;
  end
endmodule

// ### rtl/fsc_lock_check.sv
// lock bit lookup for one jtag address
module fsc_lock_check (
  input wire logic [15:0] addr,
  input wire logic [7:0] read_lock,
  input wire logic [7:0] write_lock,
  output logic read_ok,
  output logic write_ok,
  output logic is_lock_byte,
  output logic in_lock_page
);
  import fsc_pkg::*;
  logic [2:0] blk;
  assign blk = addr[15:FSC_BLK_LSB];
  assign read_ok = read_lock[blk];
  assign write_ok = write_lock[blk];
  assign is_lock_byte = (addr == FSC_RLOCK_ADDR) || (addr == FSC_WLOCK_ADDR);
  assign in_lock_page = (addr[15:FSC_PAGE_LSB] == FSC_LOCK_PAGE[15:FSC_PAGE_LSB]);
endmodule

// ### rtl/fsc_pkg.sv
// shared constants and carriers for flash security and program control
package fsc_pkg;
  localparam logic [7:0] FSC_PSC_ADDR = 8'h8f;
  localparam logic [7:0] FSC_FMC_ADDR = 8'hb6;
  localparam logic [7:0] FSC_FAL_ADDR = 8'hb7;
  localparam logic [7:0] FSC_PSC_RESET = 8'h00;
  localparam logic [7:0] FSC_FMC_RESET = 8'h80;
  localparam logic [7:0] FSC_FAL_RESET = 8'h00;
  localparam logic [7:0] FSC_PSC_MASK = 8'h07;
  localparam logic [7:0] FSC_FMC_MASK = 8'hc1;
  localparam int FSC_WE_BIT = 0;
  localparam int FSC_EE_BIT = 1;
  localparam int FSC_SP_BIT = 2;
  localparam int FSC_SOFTWARE_FLASH_WRITE_ENABLE_BIT = 0;
  localparam int FSC_READ_ALWAYS_ENABLE_BIT = 6;
  localparam int FSC_ONE_SHOT_TIMER_ENABLE_BIT = 7;
  localparam logic [15:0] FSC_RLOCK_ADDR = 16'hfdff;
  localparam logic [15:0] FSC_WLOCK_ADDR = 16'hfdfe;
  localparam logic [15:0] FSC_LOCK_PAGE = 16'hfc00;
  localparam logic [15:0] FSC_RESV_BASE = 16'hfe00;
  localparam int FSC_BLK_LSB = 13;
  localparam int FSC_PAGE_LSB = 9;
  localparam logic [7:0] FSC_ERASED = 8'hff;
  localparam logic [7:0] FSC_DENIED = 8'h00;
  localparam logic [7:0] FSC_ALL_LOCKED = 8'h00;

  typedef enum logic [1:0] {FSC_OP_READ, FSC_OP_WRITE, FSC_OP_ERASE} fsc_op_e;
  typedef enum logic [1:0] {FSC_ER_NONE, FSC_ER_PAGE, FSC_ER_MASS} fsc_er_e;

  // request into the flash array controller
  typedef struct packed {
    logic       valid;
    logic       scratch;
    fsc_op_e    op;
    fsc_er_e    span;
    logic [15:0] addr;
    logic [7:0] data;
  } fsc_freq_s;

  // request from the core or jtag side
  typedef struct packed {
    logic       valid;
    logic       scratch; // jtag only; software follows the store control bit
    fsc_op_e    op;
    logic [15:0] addr;
    logic [7:0] data;
  } fsc_req_s;
endpackage

// ### rtl/fsc_top.sv
// flash security, lock and program-store control
//
// Operation
// - read lock at 0xfdff, write/erase lock at 0xfdfe
// - each lock bit guards one 8k block; top block stops below lock bytes
// - read-lock bit zero refuses jtag reads of that block
// - write-lock bit zero blocks jtag writes and erases there
// - scratchpad locked only when all program blocks are locked
// - software may write lock page bytes but never erase it
// - top block locked still permits writing lock bytes, not erasing
// - lock bits always readable and clearable
// - jtag erase at a lock byte erases everything below reserved area
// - jtag erase elsewhere in top page erases that page only
// - read limit is access-limit value times 256
// - upper code cannot touch flash below limit; reads give zero
// - lower code unrestricted; upper code may execute lower code
// - access limit takes first write after reset only
// - limit zero gives unrestricted access
// - bit 7 enables sense-amp one-shot timer, resets to one
// - bit 6 keeps flash always in read mode
// - software writes and erases need bit 0 of flash control
// - reserved flash control bits read zero
// - scratchpad select routes software accesses to scratchpad
// - erase enable plus write enable makes a page erase
// - write enable makes a byte program
// - byte writes only clear bits; erase sets 0xff
// - core stalls during flash write or erase
module fsc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire fsc_pkg::fsc_req_s cpu_req,
  input wire logic [15:0] cpu_pc,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_stall,
  input wire fsc_pkg::fsc_req_s jtag_req,
  output logic [7:0] jtag_rdata,
  output logic jtag_done,
  output logic jtag_denied,
  output fsc_pkg::fsc_freq_s flash_req,
  input wire logic flash_busy,
  input wire logic flash_done,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] flash_old,
  input wire logic [7:0] read_lock_in,
  input wire logic [7:0] write_lock_in,
  output logic one_shot_en,
  output logic read_always_en
);
  import fsc_pkg::*;

  typedef enum logic [1:0] {FSC_IDLE, FSC_LOAD, FSC_ISSUE, FSC_WAIT} fsc_state_e;

  logic [7:0] psc_reg;
  logic [7:0] fmc_reg;
  logic [7:0] fal_reg;
  logic fal_written_reg;
  logic [15:0] limit;
  fsc_state_e state_reg;
  logic src_jtag_reg;
  logic j_rd_ok;
  logic j_wr_ok;
  logic j_lockbyte;
  logic j_lockpage;
  logic sp_locked;
  logic sp_rd_locked;
  logic upper_pc;
  logic below_limit;
  logic cpu_ok;
  logic cpu_mod;
  logic jtag_ok;
  fsc_freq_s cpu_cmd;
  fsc_freq_s jtag_cmd;

  // lock decode for the jtag address
  fsc_lock_check u_lock (
    .addr(jtag_req.addr),
    .read_lock(read_lock_in),
    .write_lock(write_lock_in),
    .read_ok(j_rd_ok),
    .write_ok(j_wr_ok),
    .is_lock_byte(j_lockbyte),
    .in_lock_page(j_lockpage)
  );

  // scratch locked when every block is
  assign sp_locked = (write_lock_in == FSC_ALL_LOCKED);
  assign sp_rd_locked = (read_lock_in == FSC_ALL_LOCKED);

  assign limit = {fal_reg, 8'h00};
  assign upper_pc = (cpu_pc >= limit);
  assign below_limit = (cpu_req.addr < limit);
  assign cpu_mod = (cpu_req.op != FSC_OP_READ);

  // software access permission
  always_comb begin
    cpu_ok = 1'b1;
    if (upper_pc && below_limit && !psc_reg[FSC_SP_BIT]) begin
      cpu_ok = 1'b0;
    end
    if (cpu_mod && !(fmc_reg[FSC_SOFTWARE_FLASH_WRITE_ENABLE_BIT] && psc_reg[FSC_WE_BIT])) begin
      cpu_ok = 1'b0;
    end
    // no software erase of lock page
    if (cpu_mod && psc_reg[FSC_EE_BIT] && !psc_reg[FSC_SP_BIT]
        && cpu_req.addr[15:FSC_PAGE_LSB] == FSC_LOCK_PAGE[15:FSC_PAGE_LSB]) begin
      cpu_ok = 1'b0;
    end
  end

  // software command build
  always_comb begin
    cpu_cmd = '0;
    cpu_cmd.valid = cpu_req.valid && cpu_ok;
    cpu_cmd.scratch = psc_reg[FSC_SP_BIT];
    cpu_cmd.addr = cpu_req.addr;
    // raw data; old byte merged in the load step
    cpu_cmd.data = cpu_req.data;
    cpu_cmd.op = FSC_OP_READ;
    cpu_cmd.span = FSC_ER_NONE;
    if (cpu_mod) begin
      if (psc_reg[FSC_EE_BIT]) begin
        cpu_cmd.op = FSC_OP_ERASE;
        cpu_cmd.span = FSC_ER_PAGE;
        cpu_cmd.data = FSC_ERASED;
      end else begin
        cpu_cmd.op = FSC_OP_WRITE;
      end
    end
  end

  // jtag permission
  always_comb begin
    jtag_ok = 1'b1;
    if (jtag_req.op == FSC_OP_READ) begin
      jtag_ok = j_rd_ok || j_lockbyte;
    end else if (jtag_req.op == FSC_OP_WRITE) begin
      jtag_ok = j_wr_ok || j_lockbyte;
    end else begin
      // mass erase is the unlock path
      jtag_ok = j_wr_ok || j_lockbyte;
    end
    // scratchpad open while any program block is open
    if (jtag_req.scratch) begin
      jtag_ok = (jtag_req.op == FSC_OP_READ) ? !sp_rd_locked : !sp_locked;
    end
  end

  // jtag command build
  always_comb begin
    jtag_cmd = '0;
    jtag_cmd.valid = jtag_req.valid && jtag_ok;
    jtag_cmd.scratch = jtag_req.scratch;
    jtag_cmd.op = jtag_req.op;
    jtag_cmd.addr = jtag_req.addr;
    // raw data; old byte merged in the load step
    jtag_cmd.data = jtag_req.data;
    jtag_cmd.span = FSC_ER_NONE;
    if (jtag_req.op == FSC_OP_ERASE) begin
      jtag_cmd.data = FSC_ERASED;
      // lock byte address means mass erase
      // rest of top page erases page
      jtag_cmd.span = (j_lockbyte && !jtag_req.scratch) ? FSC_ER_MASS : FSC_ER_PAGE;
    end
  end

  // sfr register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc_reg <= FSC_PSC_RESET;
      fmc_reg <= FSC_FMC_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == FSC_PSC_ADDR) begin
        psc_reg <= sfr_wdata & FSC_PSC_MASK;
      end
      if (sfr_addr == FSC_FMC_ADDR) begin
        fmc_reg <= sfr_wdata & FSC_FMC_MASK;
      end
    end
  end

  // one-shot access limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fal_reg <= FSC_FAL_RESET;
      fal_written_reg <= 1'b0;
    end else if (sfr_wr && sfr_addr == FSC_FAL_ADDR && !fal_written_reg) begin
      fal_reg <= sfr_wdata;
      fal_written_reg <= 1'b1;
    end
  end

  // sfr read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        FSC_PSC_ADDR: sfr_rdata <= psc_reg;
        FSC_FMC_ADDR: sfr_rdata <= fmc_reg;
        FSC_FAL_ADDR: sfr_rdata <= fal_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // sense amplifier controls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      one_shot_en <= 1'b1;
      read_always_en <= 1'b0;
    end else begin
      one_shot_en <= fmc_reg[FSC_ONE_SHOT_TIMER_ENABLE_BIT];
      read_always_en <= fmc_reg[FSC_READ_ALWAYS_ENABLE_BIT];
    end
  end

  // arbitration and flash sequencing; software has priority, jtag retries
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FSC_IDLE;
      flash_req <= '0;
      src_jtag_reg <= 1'b0;
      cpu_stall <= 1'b0;
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
      jtag_rdata <= 8'h00;
      jtag_done <= 1'b0;
      jtag_denied <= 1'b0;
    end else begin
      cpu_rvalid <= 1'b0;
      jtag_done <= 1'b0;
      jtag_denied <= 1'b0;
      case (state_reg)
        FSC_IDLE: begin
          if (cpu_req.valid) begin
            src_jtag_reg <= 1'b0;
            if (cpu_cmd.valid) begin
              // strobe waits a cycle so the stored byte at the new address shows
              flash_req <= cpu_cmd;
              flash_req.valid <= 1'b0;
              state_reg <= FSC_LOAD;
              cpu_stall <= cpu_mod;
            end else begin
              cpu_rdata <= FSC_DENIED;
              cpu_rvalid <= !cpu_mod;
            end
          end else if (jtag_req.valid) begin
            src_jtag_reg <= 1'b1;
            if (jtag_cmd.valid) begin
              flash_req <= jtag_cmd;
              flash_req.valid <= 1'b0;
              state_reg <= FSC_LOAD;
            end else begin
              jtag_rdata <= FSC_DENIED;
              jtag_done <= 1'b1;
              jtag_denied <= 1'b1;
            end
          end
        end
        // program data may only clear bits of the stored byte
        FSC_LOAD: begin
          flash_req.valid <= 1'b1;
          if (flash_req.op == FSC_OP_WRITE) begin
            flash_req.data <= flash_req.data & flash_old;
          end
          state_reg <= FSC_ISSUE;
        end
        FSC_ISSUE: begin
          flash_req.valid <= 1'b0;
          state_reg <= FSC_WAIT;
        end
        FSC_WAIT: begin
          if (flash_done && !flash_busy) begin
            state_reg <= FSC_IDLE;
            cpu_stall <= 1'b0;
            if (src_jtag_reg) begin
              jtag_rdata <= flash_rdata;
              jtag_done <= 1'b1;
            end else begin
              cpu_rdata <= flash_rdata;
              cpu_rvalid <= (flash_req.op == FSC_OP_READ);
            end
          end
        end
        default: state_reg <= FSC_IDLE;
      endcase
    end
  end

  // checks
  a_limit_once: assert property (@(posedge clk) disable iff (sys_rst)
    $past(fal_written_reg) |-> $stable(fal_reg)) else $error("limit changed after first write");
  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    fmc_reg[5:1] == 5'h00) else $error("reserved bits nonzero");
  a_denied_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == FSC_IDLE && cpu_req.valid && !cpu_mod && !cpu_ok) |=> (cpu_rvalid && cpu_rdata == 8'h00))
    else $error("blocked read not zero");
  a_wen_needed: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_cmd.valid && cpu_mod) |-> fmc_reg[FSC_SOFTWARE_FLASH_WRITE_ENABLE_BIT]) else $error("write without enable");
  a_jtag_rlock: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == FSC_IDLE && !cpu_req.valid && jtag_req.valid && jtag_req.op == FSC_OP_READ
     && !j_rd_ok && !j_lockbyte) |=> jtag_denied) else $error("locked jtag read allowed");
  a_jtag_wlock: assert property (@(posedge clk) disable iff (sys_rst)
    (jtag_cmd.valid && jtag_req.op != FSC_OP_READ) |-> (j_wr_ok || j_lockbyte)) else $error("locked write");
  a_mass_erase: assert property (@(posedge clk) disable iff (sys_rst)
    (jtag_req.op == FSC_OP_ERASE && j_lockbyte && !jtag_req.scratch) |-> jtag_cmd.span == FSC_ER_MASS)
    else $error("no mass erase");
  a_top_page: assert property (@(posedge clk) disable iff (sys_rst)
    (jtag_req.op == FSC_OP_ERASE && j_lockpage && !j_lockbyte && !jtag_req.scratch)
    |-> jtag_cmd.span == FSC_ER_PAGE) else $error("top page erase widened");
  a_scratch_lock: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == FSC_IDLE && !cpu_req.valid && jtag_req.valid && jtag_req.scratch
     && jtag_req.op != FSC_OP_READ && sp_locked) |=> jtag_denied) else $error("locked scratchpad modified");
  a_load_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == FSC_ISSUE && flash_req.op == FSC_OP_WRITE) |-> (flash_req.data & ~$past(flash_old)) == 8'h00)
    else $error("program sets a bit");
  a_one_shot: assert property (@(posedge clk) disable iff (sys_rst)
    one_shot_en == $past(fmc_reg[FSC_ONE_SHOT_TIMER_ENABLE_BIT])) else $error("one-shot enable out of step");
  a_stall_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == FSC_ISSUE && !src_jtag_reg && flash_req.op != FSC_OP_READ) |-> cpu_stall)
    else $error("core not stalled");
  a_lock_page: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_cmd.valid && cpu_cmd.op == FSC_OP_ERASE && !cpu_cmd.scratch)
    |-> cpu_req.addr[15:FSC_PAGE_LSB] != FSC_LOCK_PAGE[15:FSC_PAGE_LSB]) else $error("lock page erased");
endmodule
